// *** rtl/cocf_defs.vh ***
// Constants for the serial CMOS output clock and frame block
`ifndef COCF_DEFS_VH
`define COCF_DEFS_VH

// -----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// -----------------------------------------------------------------
`define COCF_IDX_DLY        8'h1E
`define COCF_IDX_BUF        8'h1F
`define COCF_IDX_PAT_LO     8'h20
`define COCF_IDX_PAT_MID    8'h21
`define COCF_IDX_PAT_HI     8'h22
`define COCF_IDX_PATH       8'h24
`define COCF_IDX_MODE       8'h30
`define COCF_IDX_STAT       8'h31

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define COCF_RST_DLY        8'h00
`define COCF_RST_BUF        8'h10
`define COCF_RST_PAT        8'h00
`define COCF_RST_PATH       8'h00
`define COCF_RST_MODE       8'h00

// -----------------------------------------------------------------
// Writable field masks
// -----------------------------------------------------------------
`define COCF_MSK_DLY        8'h30
`define COCF_MSK_BUF        8'hD8
`define COCF_MSK_PAT        8'hFF
`define COCF_MSK_PAT_HI     8'h0F
`define COCF_MSK_PATH       8'h3E
`define COCF_MSK_MODE       8'h07

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define COCF_DLY_HI         5
`define COCF_DLY_LO         4
`define COCF_BUF_LOWDRV     7
`define COCF_BUF_INEN       6
`define COCF_BUF_OBEN       4
`define COCF_BUF_SINGLE     3
`define COCF_PATH_AVG       5
`define COCF_PATH_MUX_HI    4
`define COCF_PATH_MUX_LO    3
`define COCF_PATH_FEAT      2
`define COCF_PATH_DEC       1
`define COCF_MODE_RES_HI    1
`define COCF_MODE_RES_LO    0
`define COCF_MODE_FPIN      2

// -----------------------------------------------------------------
// Output resolution codes and frame lengths in bits
// -----------------------------------------------------------------
`define COCF_RES_14         2'h0
`define COCF_RES_16         2'h1
`define COCF_RES_18         2'h2
`define COCF_RES_20         2'h3
`define COCF_LEN_14         5'h0E
`define COCF_LEN_16         5'h10
`define COCF_LEN_18         5'h12
`define COCF_LEN_20         5'h14

// -----------------------------------------------------------------
// Widths
// -----------------------------------------------------------------
`define COCF_WORD_W         20
`define COCF_MSB            5'h13
`define COCF_IDX_ZERO       5'h00
`define COCF_IDX_ONE        5'h01

`endif

// *** rtl/cocf_serializer.v ***
// Serializer that launches sample bits and the frame clock pattern
`timescale 1ns/1ns

module cocf_serializer
(
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_in,
   // Launch control
   input  wire        launch_in,
   input  wire [4:0]  frame_len_in,
   // Parallel words, MSB aligned
   input  wire [19:0] word_a_in,
   input  wire [19:0] word_b_in,
   input  wire [19:0] pattern_in,
   // Serial outputs
   output reg         ser_a_out,
   output reg         ser_b_out,
   output reg         frame_out,
   output reg         take_out,
   output reg  [4:0]  index_out
);

`include "cocf_defs.vh"

   reg  [19:0] hold_a_q;
   reg  [19:0] hold_b_q;
   reg  [19:0] hold_p_q;
   wire [4:0]  bit_sel;
   wire        last_bit;

   // Bit position inside the 20-bit words, MSB first
   assign bit_sel  = `COCF_MSB - index_out;
   // Greater-or-equal ends a frame cut short by a resolution change, so the
   // index never runs past the word and never selects a bit outside it
   assign last_bit = (index_out >= (frame_len_in - `COCF_IDX_ONE));

   // Launch one bit per launch pulse; words latched at frame start
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         hold_a_q  <= 20'h00000;
         hold_b_q  <= 20'h00000;
         hold_p_q  <= 20'h00000;
         ser_a_out <= 1'b0;
         ser_b_out <= 1'b0;
         frame_out <= 1'b0;
         take_out  <= 1'b0;
         index_out <= `COCF_IDX_ZERO;
      end
      else
      begin
         take_out <= 1'b0;
         if (launch_in)
         begin
            if (index_out == `COCF_IDX_ZERO)
            begin
               // New frame: launch MSB straight from the fresh words
               hold_a_q  <= word_a_in;
               hold_b_q  <= word_b_in;
               hold_p_q  <= pattern_in;
               ser_a_out <= word_a_in[`COCF_MSB];
               ser_b_out <= word_b_in[`COCF_MSB];
               frame_out <= pattern_in[`COCF_MSB];
               take_out  <= 1'b1;
            end
            else
            begin
               ser_a_out <= hold_a_q[bit_sel];
               ser_b_out <= hold_b_q[bit_sel];
               frame_out <= hold_p_q[bit_sel];
            end
            if (last_bit)
               index_out <= `COCF_IDX_ZERO;
            else
               index_out <= index_out + `COCF_IDX_ONE;
         end
      end
   end

endmodule // cocf_serializer

// *** rtl/cocf_top.v ***
// Serial CMOS output clocking, frame clock pattern and digital path control
// Operation
// - Bit clock delay code: none, advance 50 ps, delay 50 ps, delay 100 ps.
// - Bit clock buffer enable bit gates the output clock; resets to one.
// - Single-edge mode launches serial data on rising bit clock edges only.
// - Single-edge cleared (reset) launches data on both bit clock edges.
// - Twenty-bit frame pattern held over three byte registers, top nibble third.
// - With decimation bypassed the pattern follows the output resolution automatically.
// - Frame clock enable puts the frame clock on a data pin instead of data.
// - Feature path select zero bypasses the feature block; one routes through it.
// - Decimator enable bit turns the decimation filter on for both channels.
`timescale 1ns/1ns

module cocf_top
(
   // Clock and reset
   input  wire        CORE_CLK_IN,
   input  wire        RST_IN,
   // Wishbone classic slave
   input  wire        WB_CYC_IN,
   input  wire        WB_STB_IN,
   input  wire        WB_WE_IN,
   input  wire [9:0]  WB_ADR_IN,
   input  wire [3:0]  WB_SEL_IN,
   input  wire [31:0] WB_DAT_IN,
   output reg  [31:0] WB_DAT_OUT,
   output reg         WB_ACK_OUT,
   // Link bit clock from the capture side
   input  wire        BIT_CLOCK_INPUT_IN,
   // Sample words, MSB aligned, raw and from the feature block
   input  wire [19:0] SAMPLE_A_IN,
   input  wire [19:0] SAMPLE_B_IN,
   input  wire [19:0] FEATURE_A_IN,
   input  wire [19:0] FEATURE_B_IN,
   output wire        SAMPLE_TAKE_OUT,
   // Serial CMOS pins
   output reg         OUTPUT_BIT_CLOCK_OUT,
   output wire        SERIAL_A_OUT,
   output reg         SERIAL_B_OUT,
   // Pad controls
   output reg  [1:0]  BIT_CLOCK_DELAY_TRIM_OUT,
   output reg         REDUCED_DRIVE_SELECT_OUT,
   output reg         BIT_CLOCK_INPUT_ENABLE_OUT,
   // Digital path controls
   output reg         FEATURE_PATH_SELECT_OUT,
   output reg         DECIMATOR_ENABLE_OUT,
   output reg  [1:0]  CONVERTER_ROUTE_SELECT_OUT,
   output reg         CHANNEL_AVERAGE_ENABLE_OUT
);

`include "cocf_defs.vh"

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------

   // Frame length in bits for a resolution code
   function [4:0] frame_len;
      input [1:0] res;
      begin
         case (res)
            `COCF_RES_14: frame_len = `COCF_LEN_14;
            `COCF_RES_16: frame_len = `COCF_LEN_16;
            `COCF_RES_18: frame_len = `COCF_LEN_18;
            default:      frame_len = `COCF_LEN_20;
         endcase
      end
   endfunction

   // Half-duty pattern: ones over the first half of the frame
   function [19:0] auto_pattern;
      input [1:0] res;
      reg   [4:0] half;
      integer     i;
      begin
         half = frame_len(res) >> 1;
         auto_pattern = 20'h00000;
         for (i = 0; i < `COCF_WORD_W; i = i + 1)
            auto_pattern[`COCF_WORD_W - 1 - i] = (i < half);
      end
   endfunction

   // Masked byte write into a register
   function [7:0] wr_byte;
      input [7:0] old;
      input [7:0] val;
      input [7:0] msk;
      begin
         wr_byte = (old & ~msk) | (val & msk);
      end
   endfunction

   // ----------------------------------------------------------------
   // Registers and signals
   // ----------------------------------------------------------------
   reg  [7:0]  dly_q;
   reg  [7:0]  buf_q;
   reg  [7:0]  pat_lo_q;
   reg  [7:0]  pat_mid_q;
   reg  [7:0]  pat_hi_q;
   reg  [7:0]  path_q;
   reg  [7:0]  mode_q;
   reg         bclk_s1_q;
   reg         bclk_s2_q;
   reg         bclk_s3_q;
   reg  [7:0]  rd_d;
   wire [7:0]  idx;
   wire        wr_en;
   wire        req;
   wire        rise;
   wire        fall;
   wire        launch;
   wire [1:0]  res;
   wire [19:0] pattern_prog;
   wire [19:0] pattern_use;
   wire [19:0] word_a;
   wire [19:0] word_b;
   wire        ser_b;
   wire        frame_bit;
   wire [4:0]  bit_index;
   wire [4:0]  frame_len_cur;

   // Bus request decode and current resolution
   assign idx   = WB_ADR_IN[9:2];
   assign req   = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
   assign wr_en = req & WB_WE_IN & WB_SEL_IN[0];
   assign res   = mode_q[`COCF_MODE_RES_HI:`COCF_MODE_RES_LO];

   // Frame length for the current resolution, fed to the serializer
   assign frame_len_cur = frame_len(res);

   // ----------------------------------------------------------------
   // Wishbone slave: one wait state, ack one cycle
   // ----------------------------------------------------------------

   // Register writes on the low byte lane
   // Reserved bits are masked so they always read back as zero
   always @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         dly_q     <= `COCF_RST_DLY;
         buf_q     <= `COCF_RST_BUF;
         pat_lo_q  <= `COCF_RST_PAT;
         pat_mid_q <= `COCF_RST_PAT;
         pat_hi_q  <= `COCF_RST_PAT;
         path_q    <= `COCF_RST_PATH;
         mode_q    <= `COCF_RST_MODE;
      end
      else if (wr_en)
      begin
         case (idx)
            `COCF_IDX_DLY:     dly_q     <= wr_byte(dly_q, WB_DAT_IN[7:0], `COCF_MSK_DLY);
            `COCF_IDX_BUF:     buf_q     <= wr_byte(buf_q, WB_DAT_IN[7:0], `COCF_MSK_BUF);
            `COCF_IDX_PAT_LO:  pat_lo_q  <= wr_byte(pat_lo_q, WB_DAT_IN[7:0], `COCF_MSK_PAT);
            `COCF_IDX_PAT_MID: pat_mid_q <= wr_byte(pat_mid_q, WB_DAT_IN[7:0], `COCF_MSK_PAT);
            `COCF_IDX_PAT_HI:  pat_hi_q  <= wr_byte(pat_hi_q, WB_DAT_IN[7:0], `COCF_MSK_PAT_HI);
            `COCF_IDX_PATH:    path_q    <= wr_byte(path_q, WB_DAT_IN[7:0], `COCF_MSK_PATH);
            `COCF_IDX_MODE:    mode_q    <= wr_byte(mode_q, WB_DAT_IN[7:0], `COCF_MSK_MODE);
            default:           mode_q    <= mode_q;
         endcase
      end
   end

   // Read data mux; unmapped indexes read zero
   // Status shows the live bit index and the synchronised link clock level
   always @*
   begin
      case (idx)
         `COCF_IDX_DLY:     rd_d = dly_q;
         `COCF_IDX_BUF:     rd_d = buf_q;
         `COCF_IDX_PAT_LO:  rd_d = pat_lo_q;
         `COCF_IDX_PAT_MID: rd_d = pat_mid_q;
         `COCF_IDX_PAT_HI:  rd_d = pat_hi_q;
         `COCF_IDX_PATH:    rd_d = path_q;
         `COCF_IDX_MODE:    rd_d = mode_q;
         `COCF_IDX_STAT:    rd_d = {2'h0, bclk_s2_q, bit_index};
         default:           rd_d = 8'h00;
      endcase
   end

   // Acknowledge and read data register
   // Ack high blocks a held request from being taken a second time
   always @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         WB_ACK_OUT <= 1'b0;
         WB_DAT_OUT <= 32'h00000000;
      end
      else
      begin
         WB_ACK_OUT <= req;
         if (req)
            WB_DAT_OUT <= {24'h000000, rd_d};
      end
   end

   // ----------------------------------------------------------------
   // Bit clock input synchroniser and edge finder
   // ----------------------------------------------------------------

   // Two flops then an edge history flop
   // Only the second and third flops feed logic; the first may still be settling
   always @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         bclk_s1_q <= 1'b0;
         bclk_s2_q <= 1'b0;
         bclk_s3_q <= 1'b0;
      end
      else
      begin
         bclk_s1_q <= BIT_CLOCK_INPUT_IN;
         bclk_s2_q <= bclk_s1_q;
         bclk_s3_q <= bclk_s2_q;
      end
   end

   assign rise = bclk_s2_q & ~bclk_s3_q;
   assign fall = ~bclk_s2_q & bclk_s3_q;

   // Launch on rising edges only, or on both edges
   // Single-edge mode relies on the capture side doubling the link clock
   assign launch = buf_q[`COCF_BUF_SINGLE] ? rise
                                           : (rise | fall);

   // ----------------------------------------------------------------
   // Frame pattern and data path selection
   // ----------------------------------------------------------------

   // Programmed pattern; software owns values in decimation modes
   // The three bytes are not updated together; rewrite them between frames
   assign pattern_prog = {pat_hi_q[3:0], pat_mid_q, pat_lo_q};

   // Bypass uses the resolution-derived pattern instead
   // Auto pattern keeps a half-duty frame clock at every resolution
   assign pattern_use = path_q[`COCF_PATH_DEC] ? pattern_prog
                                               : auto_pattern(res);

   // Feature block in or out of the data path
   assign word_a = path_q[`COCF_PATH_FEAT] ? FEATURE_A_IN : SAMPLE_A_IN;
   assign word_b = path_q[`COCF_PATH_FEAT] ? FEATURE_B_IN : SAMPLE_B_IN;

   // ----------------------------------------------------------------
   // Serializer
   // ----------------------------------------------------------------
   cocf_serializer u_ser
   (
      .clk_in       (CORE_CLK_IN),
      .rst_in       (RST_IN),
      .launch_in    (launch),
      .frame_len_in (frame_len_cur),
      .word_a_in    (word_a),
      .word_b_in    (word_b),
      .pattern_in   (pattern_use),
      .ser_a_out    (SERIAL_A_OUT),
      .ser_b_out    (ser_b),
      .frame_out    (frame_bit),
      .take_out     (SAMPLE_TAKE_OUT),
      .index_out    (bit_index)
   );

   // ----------------------------------------------------------------
   // Output pins and control outputs
   // ----------------------------------------------------------------

   // Output bit clock, data pin B mux and pad and path controls
   // Pin B and the bit clock leave one cycle after pin A
   // Picosecond trim cannot be made in logic; the code goes to the pad delay cell
   always @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         OUTPUT_BIT_CLOCK_OUT       <= 1'b0;
         SERIAL_B_OUT               <= 1'b0;
         BIT_CLOCK_DELAY_TRIM_OUT   <= 2'h0;
         REDUCED_DRIVE_SELECT_OUT   <= 1'b0;
         BIT_CLOCK_INPUT_ENABLE_OUT <= 1'b0;
         FEATURE_PATH_SELECT_OUT    <= 1'b0;
         DECIMATOR_ENABLE_OUT       <= 1'b0;
         CONVERTER_ROUTE_SELECT_OUT <= 2'h0;
         CHANNEL_AVERAGE_ENABLE_OUT <= 1'b0;
      end
      else
      begin
         OUTPUT_BIT_CLOCK_OUT       <= bclk_s3_q & buf_q[`COCF_BUF_OBEN];
         SERIAL_B_OUT               <= mode_q[`COCF_MODE_FPIN] ? frame_bit : ser_b;
         BIT_CLOCK_DELAY_TRIM_OUT   <= dly_q[`COCF_DLY_HI:`COCF_DLY_LO];
         REDUCED_DRIVE_SELECT_OUT   <= buf_q[`COCF_BUF_LOWDRV];
         BIT_CLOCK_INPUT_ENABLE_OUT <= buf_q[`COCF_BUF_INEN];
         FEATURE_PATH_SELECT_OUT    <= path_q[`COCF_PATH_FEAT];
         DECIMATOR_ENABLE_OUT       <= path_q[`COCF_PATH_DEC];
         CONVERTER_ROUTE_SELECT_OUT <= path_q[`COCF_PATH_MUX_HI:`COCF_PATH_MUX_LO];
         CHANNEL_AVERAGE_ENABLE_OUT <= path_q[`COCF_PATH_AVG];
      end
   end

endmodule // cocf_top

// *** verification/cocf_top_assertions.sv ***
// Port-level checks for the output clock and frame block
`timescale 1ns/1ns

module cocf_top_chk
(
   // Clock and reset
   input wire        CORE_CLK_IN,
   input wire        RST_IN,
   // Register bus
   input wire        WB_CYC_IN,
   input wire        WB_STB_IN,
   input wire        WB_WE_IN,
   input wire [9:0]  WB_ADR_IN,
   input wire [3:0]  WB_SEL_IN,
   input wire [31:0] WB_DAT_IN,
   input wire [31:0] WB_DAT_OUT,
   input wire        WB_ACK_OUT,
   // Link side
   input wire        SAMPLE_TAKE_OUT,
   input wire        OUTPUT_BIT_CLOCK_OUT,
   // Controls
   input wire [1:0]  BIT_CLOCK_DELAY_TRIM_OUT,
   input wire        FEATURE_PATH_SELECT_OUT,
   input wire        DECIMATOR_ENABLE_OUT,
   input wire [1:0]  CONVERTER_ROUTE_SELECT_OUT,
   input wire        CHANNEL_AVERAGE_ENABLE_OUT
);
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (RST_IN);

   // A request being taken, and a full write with its answer
   sequence s_req(w, a);
      WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && WB_WE_IN == w && WB_ADR_IN[9:2] == a;
   endsequence
   sequence s_wdone(a);
      s_req(1'b1, a) ##0 WB_SEL_IN[0] ##1 WB_ACK_OUT;
   endsequence

   a_ack_answer: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
      else $error("request not answered next cycle");
   a_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property ($rose(WB_ACK_OUT) |-> $past(WB_CYC_IN && WB_STB_IN))
      else $error("ack without request");
   a_unmapped_zero: assert property (s_req(1'b0, 8'h23) |=> WB_ACK_OUT && WB_DAT_OUT == 32'h0)
      else $error("unmapped read not zero");
   a_trim_copy: assert property (s_wdone(8'h1E) |=> BIT_CLOCK_DELAY_TRIM_OUT == $past(WB_DAT_IN[5:4]))
      else $error("delay trim not taken");
   a_lane_off: assert property (s_req(1'b1, 8'h1E) ##0 !WB_SEL_IN[0]
      |-> ##2 BIT_CLOCK_DELAY_TRIM_OUT == $past(BIT_CLOCK_DELAY_TRIM_OUT, 2))
      else $error("write with lane off changed trim");
   a_path_copy: assert property (s_wdone(8'h24) |=> {CHANNEL_AVERAGE_ENABLE_OUT, CONVERTER_ROUTE_SELECT_OUT,
      FEATURE_PATH_SELECT_OUT, DECIMATOR_ENABLE_OUT} == $past(WB_DAT_IN[5:1]))
      else $error("path controls not taken");
   a_clock_off: assert property (s_req(1'b1, 8'h1F) ##0 WB_SEL_IN[0] && !WB_DAT_IN[4]
      |-> ##3 !OUTPUT_BIT_CLOCK_OUT [*8])
      else $error("bit clock runs with buffer off");
   a_take_gap: assert property (SAMPLE_TAKE_OUT |=> !SAMPLE_TAKE_OUT [*8])
      else $error("frames too close");
endmodule // cocf_top_chk

bind cocf_top cocf_top_chk chk_u
(
   .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
   .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
   .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .SAMPLE_TAKE_OUT(SAMPLE_TAKE_OUT),
   .OUTPUT_BIT_CLOCK_OUT(OUTPUT_BIT_CLOCK_OUT), .BIT_CLOCK_DELAY_TRIM_OUT(BIT_CLOCK_DELAY_TRIM_OUT),
   .FEATURE_PATH_SELECT_OUT(FEATURE_PATH_SELECT_OUT), .DECIMATOR_ENABLE_OUT(DECIMATOR_ENABLE_OUT),
   .CONVERTER_ROUTE_SELECT_OUT(CONVERTER_ROUTE_SELECT_OUT),
   .CHANNEL_AVERAGE_ENABLE_OUT(CHANNEL_AVERAGE_ENABLE_OUT)
);

// *** verification/cocf_rx_model.sv ***
// Capture-side model: makes the link bit clock and shifts in serial bits
`timescale 1ns/1ns

module cocf_rx_model
(
   // Core clock and mode
   input  wire        clk_in,
   input  wire        single_in,
   // Pins from the block
   input  wire        obc_in,
   input  wire        ser_a_in,
   input  wire        ser_b_in,
   // Link clock and captured bits
   output reg         bclk_out,
   output reg  [19:0] cap_a_out,
   output reg  [19:0] cap_b_out
);
   reg obc_q = 1'b0;
   reg hit_q = 1'b0;

   // Link clock, offset from the core clock, twice as fast for single-edge
   initial
   begin
      bclk_out = 1'b0;
      #7;
      forever
      begin
         #(single_in ? 100 : 200);
         bclk_out = ~bclk_out;
      end
   end

   // Take one bit two cycles after each launching edge, MSB first
   always @(posedge clk_in)
   begin
      obc_q <= obc_in;
      hit_q <= (obc_in != obc_q) && (obc_in || !single_in);
      if (hit_q)
      begin
         cap_a_out <= {cap_a_out[18:0], ser_a_in};
         cap_b_out <= {cap_b_out[18:0], ser_b_in};
      end
   end
endmodule // cocf_rx_model

// *** verification/tb_cocf_top.sv ***
// Self-checking bench for the output clock and frame block
`timescale 1ns/1ns
`include "cocf_defs.vh"

module tb_cocf_top;
   logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, sgl = 0;
   logic [9:0]  adr = 0;
   logic [3:0]  sel = 0;
   logic [31:0] wdat = 0;
   logic [19:0] sa = 0, sb = 0, fa = 0, fb = 0;
   wire  [19:0] ca, cb;
   wire  [31:0] rdat;
   wire         ack, take, obc, sera, serb, bclk, fps, dec, avg, rdrv, inen;
   wire  [1:0]  trim, route;
   int          bad_count = 0, n_tests = 0, nl = 14;
   logic [31:0] rq[$];
   logic [19:0] qa[$], qb[$];
   logic [7:0]  idx [6] = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h24};
   logic [7:0]  rv [6] = '{`COCF_RST_DLY, `COCF_RST_BUF, `COCF_RST_PAT, `COCF_RST_PAT, `COCF_RST_PAT, `COCF_RST_PATH};
   logic [7:0]  mk [6] = '{`COCF_MSK_DLY, `COCF_MSK_BUF, `COCF_MSK_PAT, `COCF_MSK_PAT, `COCF_MSK_PAT_HI, `COCF_MSK_PATH};

   always #25 clk = ~clk;

   cocf_top dut_u
   (
      .CORE_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
      .BIT_CLOCK_INPUT_IN(bclk), .SAMPLE_A_IN(sa), .SAMPLE_B_IN(sb), .FEATURE_A_IN(fa),
      .FEATURE_B_IN(fb), .SAMPLE_TAKE_OUT(take), .OUTPUT_BIT_CLOCK_OUT(obc), .SERIAL_A_OUT(sera),
      .SERIAL_B_OUT(serb), .BIT_CLOCK_DELAY_TRIM_OUT(trim), .REDUCED_DRIVE_SELECT_OUT(rdrv),
      .BIT_CLOCK_INPUT_ENABLE_OUT(inen), .FEATURE_PATH_SELECT_OUT(fps), .DECIMATOR_ENABLE_OUT(dec),
      .CONVERTER_ROUTE_SELECT_OUT(route), .CHANNEL_AVERAGE_ENABLE_OUT(avg)
   );

   cocf_rx_model rx_u
   (
      .clk_in(clk), .single_in(sgl), .obc_in(obc), .ser_a_in(sera), .ser_b_in(serb),
      .bclk_out(bclk), .cap_a_out(ca), .cap_b_out(cb)
   );

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   // One classic bus cycle, held until ack is seen
   task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d, input logic s);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h000000, d};
      sel <= {3'b000, s};
      do
      begin
         @(negedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 40);
      @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 40) bad_count++;
   endtask

   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      wb(1'b1, i, d, 1'b1);
   endtask

   task automatic rd(input logic [7:0] i, input logic [31:0] e);
      rq.push_back(e);
      wb(1'b0, i, 8'h00, 1'b1);
   endtask

   task automatic takes(input int k);
      int n;
      n = 0;
      repeat (k)
      do
      begin
         @(negedge clk);
         n++;
      end
      while (take !== 1'b1 && n < 3000);
      if (n >= 3000) bad_count++;
   endtask

   // Set up a serial mode, skip settling frames, then expect one full frame
   task automatic ser(input logic s, input logic [1:0] r, input logic d, input logic f,
                      input logic m, input logic [19:0] p);
      sgl <= s;
      wr(8'h1F, {4'h1, s, 3'b000});
      wr(8'h30, {5'b00000, m, r});
      wr(8'h24, {5'b00000, f, d, 1'b0});
      wr(8'h20, p[7:0]);
      wr(8'h21, p[15:8]);
      wr(8'h22, {4'h0, p[19:16]});
      chk("path", {f, d}, {fps, dec});
      takes(2);
      // Step off the take edge so the monitor cannot pick the note up early
      @(posedge clk);
      nl = 14 + 2 * r;
      qa.push_back((f ? fa : sa) >> (20 - nl));
      qb.push_back((m ? (d ? p : ~(20'hFFFFF >> (nl / 2))) : (f ? fb : sb)) >> (20 - nl));
      takes(1);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Compare read data and finished frames against the oldest notes
   always @(negedge clk)
   begin
      if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) chk("read data", rq.pop_front(), rdat);
      if (take === 1'b1 && qa.size() > 0)
      begin
         chk("data bits", qa.pop_front(), ca & (20'hFFFFF >> (20 - nl)));
         chk("frame bits", qb.pop_front(), cb & (20'hFFFFF >> (20 - nl)));
      end
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      wrap_up();
   end

   initial
   begin
      logic [7:0] v;
      void'($urandom(98));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      sa <= 20'($urandom);
      sb <= 20'($urandom);
      fa <= 20'($urandom);
      fb <= 20'($urandom);
      for (int i = 0; i < 6; i++) rd(idx[i], {24'h000000, rv[i]});
      rd(8'h23, 32'h00000000);
      for (int i = 0; i < 6; i++)
      begin
         v = 8'($urandom);
         if (i == 1) v[4] = 1'b1;
         wr(idx[i], v);
         rd(idx[i], {24'h000000, v & mk[i]});
         if (i == 1) chk("drive", v[7:6], {rdrv, inen});
      end
      wr(8'h1E, 8'h10);
      wb(1'b1, 8'h1E, 8'h30, 1'b0);
      rd(8'h1E, 32'h00000010);
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h1E, 8'(c << 4));
         @(negedge clk);
         chk("trim", c, trim);
      end
      wr(8'h1F, 8'h00);
      v = 8'h00;
      repeat (4) @(negedge clk);
      repeat (40) @(negedge clk) v[0] = v[0] | obc;
      chk("bit clock", 0, v[0]);
      ser(1'b0, `COCF_RES_14, 1'b0, 1'b0, 1'b1, 20'h12345);
      ser(1'b1, `COCF_RES_20, 1'b0, 1'b1, 1'b1, 20'h00000);
      ser(1'b0, `COCF_RES_16, 1'b1, 1'b0, 1'b1, 20'($urandom));
      ser(1'b1, `COCF_RES_18, 1'b1, 1'b1, 1'b1, 20'hFF800);
      ser(1'b0, `COCF_RES_14, 1'b1, 1'b0, 1'b1, 20'hFFFFF);
      ser(1'b1, `COCF_RES_16, 1'b0, 1'b1, 1'b0, 20'h00000);
      wrap_up();
   end
endmodule // tb_cocf_top
